// file: rtl/asq_pkg.sv
// Purpose: Shared constants and types for the A/D scan sequencer.
// Assumes: One peripheral clock; the analog core sits outside.
// Notes: Result memory index map and trigger select codes live here.
`default_nettype none
package asq_pkg;
	localparam int NUM_CH     = 10;
	localparam int CH_W       = 4;
	localparam int RES_W      = 12;
	localparam int DATA_W     = 16;
	localparam int MEM_AW     = 4;
	localparam int PEND_W     = 11;
	localparam int TRIG_N     = 32;
	localparam int TRIG_IDX_W = 5;
	localparam int TSEL_W     = 6;
	localparam int DBL_W      = 5;
	localparam int SAMP_W     = 8;
	localparam int ASSIST_W   = 5;
	localparam int ADDC_W     = 3;
	localparam int SH_CH      = 3;

	localparam logic [CH_W-1:0]   IDX_INTREF = 4'ha;
	localparam logic [CH_W-1:0]   IDX_DUP    = 4'hb;
	localparam logic [CH_W-1:0]   IDX_DUPA   = 4'hc;
	localparam logic [CH_W-1:0]   IDX_DUPB   = 4'hd;
	localparam logic [TSEL_W-1:0] TSEL_EXT   = 6'h3e;
	localparam logic [ADDC_W-1:0] ADDC_AVG2  = 3'h1;
	localparam logic [ADDC_W-1:0] ADDC_AVG4  = 3'h3;

	typedef enum logic [1:0]
	{
		MODE_SINGLE = 2'b00,
		MODE_CONT   = 2'b01,
		MODE_GROUP  = 2'b10
	} asq_mode_t;

	typedef enum logic [1:0]
	{
		KIND_SW    = 2'b00,
		KIND_TIMER = 2'b01,
		KIND_EXT   = 2'b10
	} asq_kind_t;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT  = 2'b10,
		ST_DONE  = 2'b11
	} asq_state_t;
endpackage
`default_nettype wire

// file: rtl/asq_mem_if.sv
// Purpose: Link between scan control and its result memory.
// Assumes: Single clock; control drives writes and reads.
// Notes: Write wins over a read-clear of the same word.
`default_nettype none
interface asq_mem_if #(parameter int AW = 4, parameter int W = 16);
	logic          wrEn;
	logic [AW-1:0] wrIdx;
	logic [W-1:0]  wrData;
	logic          rdEn;
	logic [AW-1:0] rdIdx;
	logic          rdClr;
	logic [W-1:0]  rdData;
	modport ctrl (output wrEn, wrIdx, wrData, rdEn, rdIdx, rdClr, input rdData);
	modport store (input wrEn, wrIdx, wrData, rdEn, rdIdx, rdClr, output rdData);
endinterface
`default_nettype wire

// file: rtl/asq_result_mem.sv
// Purpose: Result register file with registered read and clear on read.
// Assumes: Reset clears every word.
// Notes: Unwritten words read as zero.
`default_nettype none
module asq_result_mem #(
	parameter int AW = 4,
	parameter int W  = 16
)(
	input wire logic clk,   // Clock
	input wire logic srst,  // Sync reset
	input wire logic clkEn, // Clock enable
	asq_mem_if.store port   // Memory port
);
	logic [W-1:0] mem [2**AW];
	logic         clrHit;

	assign clrHit = port.rdEn && port.rdClr && !(port.wrEn && port.wrIdx == port.rdIdx);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			port.rdData <= '0;
			for (int i = 0; i < 2**AW; i++)
				mem[i] <= '0;
		end
		else if (clkEn)
		begin
			if (port.rdEn)
				port.rdData <= mem[port.rdIdx];
			if (clrHit)
				mem[port.rdIdx] <= '0;
			if (port.wrEn)
				mem[port.wrIdx] <= port.wrData;
		end
	end
endmodule // asq_result_mem
`default_nettype wire

// file: rtl/asq_scan_seq.sv
// Purpose: Scan sequencer of a 12-bit successive-approximation converter.
// Assumes: Core pulses convDone with convResult once per convStart.
// Notes: Config inputs are static while a scan runs.
`default_nettype none
module asq_scan_seq
	import asq_pkg::*;
(
	input  wire logic                  mclk,                // Clock
	input  wire logic                  srst,                // Sync reset
	input  wire logic                  clkEn,               // Clock enable
	input  wire logic [1:0]            scanMode,            // Scan mode
	input  wire logic                  swStartA,            // Software start A
	input  wire logic                  swStartB,            // Software start B
	input  wire logic                  stopReq,             // Stop scanning
	input  wire logic [NUM_CH-1:0]     chanSelA,            // Group A channels
	input  wire logic [NUM_CH-1:0]     chanSelB,            // Group B channels
	input  wire logic                  intRefEn,            // Convert reference outside group and double modes
	input  wire logic [NUM_CH-1:0]     addChanSel,          // Add/average channels
	input  wire logic [ADDC_W-1:0]     addCount,            // Conversions minus one
	input  wire logic                  averageEnable,       // Average 2 or 4 conversions, not sum
	input  wire logic [TSEL_W-1:0]     groupATriggerSel,    // Trigger for A
	input  wire logic [TSEL_W-1:0]     groupBTriggerSel,    // Trigger for B
	input  wire logic [TRIG_N-1:0]     timerTrig,           // Timer trigger levels
	input  wire logic                  extAsyncTriggerPinN, // External trigger pin
	input  wire logic                  doubleTrigEnable,    // Double trigger mode
	input  wire logic [DBL_W-1:0]      doubleTrigChannelSel,// Double channel
	input  wire logic                  doubleTrigExtEn,     // Per-type duplicates
	input  wire logic                  groupAPriorityEn,    // A preempts B
	input  wire logic                  groupBRestartEn,     // Rescan B after A
	input  wire logic                  groupBRepeatScan,    // Repeat B scan
	input  wire logic [SAMP_W-1:0]     samplingStates,      // Sampling count
	input  wire logic [SAMP_W-1:0]     shSamplingTime,      // Held channel sampling
	input  wire logic [ASSIST_W-1:0]   disconnectAssistSel, // Disconnect assist
	input  wire logic                  autoClearEn,         // Clear on read
	input  wire logic                  transferEnMain,      // Main transfer request
	input  wire logic                  transferEnB,         // B transfer request
	output logic                       convStart,           // Start conversion
	output logic                       convAbort,           // Abort conversion
	output logic [CH_W-1:0]            convChannel,         // Channel to convert
	output logic                       convIntRef,          // Convert reference
	output logic [SAMP_W-1:0]          convSampleStates,    // Sampling states
	output logic [ASSIST_W-1:0]        convAssist,          // Assist setting
	input  wire logic                  convDone,            // Result valid
	input  wire logic [RES_W-1:0]      convResult,          // Result
	input  wire logic                  rdEn,                // Read result
	input  wire logic [MEM_AW-1:0]     rdIdx,               // Result index
	output logic [DATA_W-1:0]          rdData,              // Read data
	output logic                       scanEndIrq,          // Scan end pulse
	output logic                       groupBEndIrq,        // Group B end pulse
	output logic                       transferReqMain,     // Transfer request
	output logic                       transferReqB,        // Transfer request B
	output logic                       doublePending        // First double done
);
	asq_mem_if #(.AW(MEM_AW), .W(DATA_W)) memIf ();

	asq_result_mem #(.AW(MEM_AW), .W(DATA_W)) uMem (
		.clk   (mclk),
		.srst  (srst),
		.clkEn (clkEn),
		.port  (memIf.store)
	);

	function automatic logic trigHit(
		input logic [TSEL_W-1:0] sel,
		input logic [TRIG_N-1:0] rise,
		input logic              ext
	);
		logic hit;
		hit = 1'b0;
		if (sel == TSEL_EXT)
			hit = ext;
		else if (sel < TSEL_W'(TRIG_N))
			hit = rise[sel[TRIG_IDX_W-1:0]];
		return hit;
	endfunction

	function automatic logic [CH_W-1:0] firstSet(input logic [PEND_W-1:0] v);
		logic [CH_W-1:0] idx;
		idx = '0;
		for (int i = PEND_W - 1; i >= 0; i--)
			if (v[i])
				idx = CH_W'(i);
		return idx;
	endfunction

	asq_state_t            stateR;
	asq_kind_t             kindR;
	logic [PEND_W-1:0]     pendR;
	logic [DATA_W-1:0]     accR;
	logic [ADDC_W-1:0]     rptR;
	logic                  curBR;
	logic                  pendAR;
	logic                  pendBR;
	logic                  rescanBR;
	logic [TRIG_N-1:0]     timerQR;
	logic                  extS1R;
	logic                  extS2R;
	logic                  extS3R;
	logic                  extLevelR;
	logic                  wrEnR;
	logic [CH_W-1:0]       wrIdxR;
	logic [DATA_W-1:0]     wrDataR;

	wire                   isGroup   = (scanMode == MODE_GROUP);
	wire                   isCont    = (scanMode == MODE_CONT);
	wire                   dblOn     = doubleTrigEnable && !isCont;
	wire [TRIG_N-1:0]      timerRise = timerTrig & ~timerQR;
	wire                   extAgree  = (extS2R == extS3R);
	wire                   extFall   = extAgree && !extS3R && extLevelR;
	wire                   trigAEv   = swStartA || trigHit(groupATriggerSel, timerRise, extFall);
	wire                   trigBEv   = isGroup
		&& (swStartB || trigHit(groupBTriggerSel, timerRise, extFall));
	wire asq_kind_t        kindA     = swStartA ? KIND_SW
		: (groupATriggerSel == TSEL_EXT) ? KIND_EXT : KIND_TIMER;
	wire [CH_W-1:0]        dblCh     = doubleTrigChannelSel[CH_W-1:0];
	wire [PEND_W-1:0]      dblHot    = PEND_W'(1) << dblCh;
	wire [PEND_W-1:0]      loadA     = dblOn ? dblHot
		: {intRefEn && !isGroup, chanSelA};
	wire [PEND_W-1:0]      loadB     = {1'b0, chanSelB};
	wire [CH_W-1:0]        curCh     = firstSet(pendR);
	wire [PEND_W-1:0]      curHot    = PEND_W'(1) << curCh;
	wire                   curIntRef = (curCh == IDX_INTREF);
	wire                   curAdd    = !curIntRef && addChanSel[curCh];
	wire                   lastRep   = !curAdd || (rptR == addCount);
	wire [DATA_W-1:0]      sum       = accR + DATA_W'(convResult);
	wire                   avg2      = averageEnable && addCount == ADDC_AVG2;
	wire                   avg4      = averageEnable && addCount == ADDC_AVG4;
	wire [DATA_W-1:0]      combined  = !curAdd ? DATA_W'(convResult)
		: avg4 ? (sum >> 2) : avg2 ? (sum >> 1) : sum;
	wire                   dupSlot   = dblOn && doublePending && !curBR;
	wire [CH_W-1:0]        dupIdx    = !doubleTrigExtEn ? IDX_DUP
		: (kindR == KIND_TIMER) ? IDX_DUPA : (kindR == KIND_EXT) ? IDX_DUPB : IDX_DUP;
	wire [CH_W-1:0]        destIdx   = curIntRef ? IDX_INTREF : dupSlot ? dupIdx : curCh;
	wire                   busyB     = (stateR != ST_IDLE) && curBR;
	wire                   preemptA  = isGroup && groupAPriorityEn && pendAR && busyB;
	wire                   startA    = (stateR == ST_IDLE) && pendAR;
	wire                   startB    = (stateR == ST_IDLE) && !pendAR && isGroup
		&& (pendBR || rescanBR);
	wire                   takeA     = startA || preemptA;
	wire                   scanOver  = (stateR == ST_DONE) && (pendR == '0);

	assign memIf.wrEn   = wrEnR;
	assign memIf.wrIdx  = wrIdxR;
	assign memIf.wrData = wrDataR;
	assign memIf.rdEn   = rdEn;
	assign memIf.rdIdx  = rdIdx;
	assign memIf.rdClr  = autoClearEn;
	assign rdData       = memIf.rdData;

	// External pin: three stages, change accepted once stages two and three agree
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			extS1R    <= 1'b1;
			extS2R    <= 1'b1;
			extS3R    <= 1'b1;
			extLevelR <= 1'b1;
			timerQR   <= '0;
		end
		else if (clkEn)
		begin
			extS1R  <= extAsyncTriggerPinN;
			extS2R  <= extS1R;
			extS3R  <= extS2R;
			timerQR <= timerTrig;
			if (extAgree)
				extLevelR <= extS3R;
		end
	end

	// Pending trigger flags; a new trigger wins over consumption
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pendAR <= 1'b0;
			pendBR <= 1'b0;
			kindR  <= KIND_SW;
		end
		else if (clkEn)
		begin
			pendAR <= !stopReq && ((pendAR && !takeA) || trigAEv);
			pendBR <= !stopReq && ((pendBR && !startB) || trigBEv);
			if (trigAEv)
				kindR <= kindA;
		end
	end

	// Scan control
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			stateR           <= ST_IDLE;
			pendR            <= '0;
			accR             <= '0;
			rptR             <= '0;
			curBR            <= 1'b0;
			rescanBR         <= 1'b0;
			doublePending    <= 1'b0;
			convStart        <= 1'b0;
			convAbort        <= 1'b0;
			convChannel      <= '0;
			convIntRef       <= 1'b0;
			convSampleStates <= '0;
			convAssist       <= '0;
			wrEnR            <= 1'b0;
			wrIdxR           <= '0;
			wrDataR          <= '0;
			scanEndIrq       <= 1'b0;
			groupBEndIrq     <= 1'b0;
			transferReqMain  <= 1'b0;
			transferReqB     <= 1'b0;
		end
		else if (clkEn)
		begin
			convStart       <= 1'b0;
			convAbort       <= 1'b0;
			wrEnR           <= 1'b0;
			scanEndIrq      <= 1'b0;
			groupBEndIrq    <= 1'b0;
			transferReqMain <= 1'b0;
			transferReqB    <= 1'b0;
			convAssist      <= disconnectAssistSel;
			if (stopReq)
			begin
				convAbort     <= (stateR != ST_IDLE);
				stateR        <= ST_IDLE;
				pendR         <= '0;
				rescanBR      <= 1'b0;
				doublePending <= 1'b0;
			end
			else if (preemptA)
			begin
				convAbort <= 1'b1;
				rescanBR  <= groupBRestartEn;
				pendR     <= loadA;
				curBR     <= 1'b0;
				accR      <= '0;
				rptR      <= '0;
				stateR    <= ST_ISSUE;
			end
			else if (startA)
			begin
				pendR  <= loadA;
				curBR  <= 1'b0;
				accR   <= '0;
				rptR   <= '0;
				stateR <= ST_ISSUE;
			end
			else if (startB)
			begin
				pendR    <= loadB;
				curBR    <= 1'b1;
				rescanBR <= 1'b0;
				accR     <= '0;
				rptR     <= '0;
				stateR   <= ST_ISSUE;
			end
			else
			begin
				case (stateR)
					ST_ISSUE:
					begin
						convStart        <= 1'b1;
						convChannel      <= curCh;
						convIntRef       <= curIntRef;
						convSampleStates <= (curCh < CH_W'(SH_CH)) ? shSamplingTime
							: samplingStates;
						stateR           <= ST_WAIT;
					end
					ST_WAIT:
					begin
						if (convDone && lastRep)
						begin
							wrEnR   <= 1'b1;
							wrIdxR  <= destIdx;
							wrDataR <= combined;
							pendR   <= pendR & ~curHot;
							accR    <= '0;
							rptR    <= '0;
							stateR  <= ST_DONE;
						end
						else if (convDone)
						begin
							accR   <= sum;
							rptR   <= rptR + ADDC_W'(1);
							stateR <= ST_ISSUE;
						end
					end
					ST_DONE:
					begin
						if (pendR != '0)
							stateR <= ST_ISSUE;
						else if (curBR)
						begin
							groupBEndIrq <= 1'b1;
							transferReqB <= transferEnB;
							rescanBR     <= groupBRepeatScan;
							stateR       <= ST_IDLE;
						end
						else if (dblOn && !doublePending)
						begin
							doublePending <= 1'b1;
							stateR        <= ST_IDLE;
						end
						else
						begin
							scanEndIrq      <= 1'b1;
							transferReqMain <= transferEnMain;
							doublePending   <= 1'b0;
							if (isCont)
							begin
								pendR  <= loadA;
								stateR <= ST_ISSUE;
							end
							else
								stateR <= ST_IDLE;
						end
					end
					default:
						stateR <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // asq_scan_seq
`default_nettype wire

// file: verif/asq_core_model.sv
// Purpose: Behavioural analog core that answers the scan sequencer.
// Assumes: One conversion at a time; an abort drops it.
// Notes: Result lines change every cycle outside the done pulse.
`default_nettype none
module asq_core_model
	import asq_pkg::*;
(
	input  wire logic            mclk,        // Clock
	input  wire logic            convStart,   // Start request
	input  wire logic            convAbort,   // Abort request
	input  wire logic [CH_W-1:0] convChannel, // Channel
	input  wire logic [7:0]      resBias,     // Low result byte
	input  wire logic [7:0]      lat,         // Conversion cycles
	output var logic             convDone,    // Result valid
	output var logic [RES_W-1:0] convResult   // Result
);
	timeunit 1ns;
	timeprecision 1ns;
	int               cnt = 0;
	logic [RES_W-1:0] res = '0;
	initial convDone = '0;
	initial convResult = '0;
	always @(posedge mclk)
	begin
		convDone <= '0;
		convResult <= ~convResult;
		if (convAbort)
			cnt <= 0;
		else if (convStart)
		begin
			cnt <= lat;
			res <= {convChannel, resBias};
		end
		else if (cnt == 1)
		begin
			cnt <= 0;
			convDone <= '1;
			convResult <= res;
		end
		else if (cnt > 1)
			cnt <= cnt - 1;
	end
endmodule // asq_core_model
`default_nettype wire

// file: verif/asq_scan_seq_properties.sv
// Purpose: Port-level timing checks for the scan sequencer.
// Assumes: clkEn stays high.
// Notes: Bound into every sequencer instance.
`default_nettype none
module asq_scan_seq_properties
	import asq_pkg::*;
(
	input wire logic                mclk,                // Clock
	input wire logic                srst,                // Reset
	input wire logic [1:0]          scanMode,            // Mode
	input wire logic                swStartA,            // Start A
	input wire logic                stopReq,             // Stop
	input wire logic                doubleTrigEnable,    // Double
	input wire logic                groupAPriorityEn,    // Priority
	input wire logic                transferEnMain,      // Gate main
	input wire logic                transferEnB,         // Gate B
	input wire logic [ASSIST_W-1:0] disconnectAssistSel, // Assist
	input wire logic                convStart,           // Start
	input wire logic                convAbort,           // Abort
	input wire logic [CH_W-1:0]     convChannel,         // Channel
	input wire logic                convIntRef,          // Reference
	input wire logic [ASSIST_W-1:0] convAssist,          // Assist out
	input wire logic                convDone,            // Done
	input wire logic                scanEndIrq,          // Main end
	input wire logic                groupBEndIrq,        // B end
	input wire logic                transferReqMain,     // Main request
	input wire logic                transferReqB,        // B request
	input wire logic                doublePending        // First done
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	AST_IRQ_LAT: assert property (scanEndIrq |-> $past(convDone, 2))
		else $error("scan end without conversion");
	AST_GB_LAT: assert property (groupBEndIrq
		|-> $past(convDone, 2) && scanMode == MODE_GROUP)
		else $error("group B end misplaced");
	AST_ONE_IRQ: assert property (!(scanEndIrq && groupBEndIrq))
		else $error("both end pulses at once");
	AST_DBL_SECOND: assert property (scanEndIrq && doubleTrigEnable
		&& scanMode != MODE_CONT |-> $past(doublePending))
		else $error("double scan ended early");
	AST_XFER_MAIN: assert property (transferReqMain |-> scanEndIrq && transferEnMain)
		else $error("main request without end");
	AST_XFER_B: assert property (transferReqB |-> groupBEndIrq && transferEnB)
		else $error("B request without end");
	AST_START_GAP: assert property (convStart |=> !convStart [*2])
		else $error("starts too close");
	AST_INTREF: assert property (convStart && convIntRef |-> convChannel == IDX_INTREF)
		else $error("reference channel wrong");
	AST_ASSIST: assert property (!$past(srst) |-> convAssist == $past(disconnectAssistSel))
		else $error("assist not passed");
	AST_STOP: assert property (stopReq && !swStartA |-> ##2 !convStart [*4])
		else $error("start after stop");
	AST_ABORT: assert property (convAbort
		|-> $past(stopReq) || $past(stopReq, 2) || groupAPriorityEn)
		else $error("abort without cause");
	cover property (scanEndIrq && doubleTrigEnable);
	cover property (groupBEndIrq);
	cover property (convAbort && groupAPriorityEn);
endmodule // asq_scan_seq_properties
bind asq_scan_seq asq_scan_seq_properties props_i (.mclk, .srst, .scanMode, .swStartA, .stopReq,
	.doubleTrigEnable, .groupAPriorityEn, .transferEnMain, .transferEnB, .disconnectAssistSel,
	.convStart, .convAbort, .convChannel, .convIntRef, .convAssist, .convDone, .scanEndIrq,
	.groupBEndIrq, .transferReqMain, .transferReqB, .doublePending);
`default_nettype wire

// file: verif/tb.sv
// Purpose: Self-checking bench for the scan sequencer.
// Assumes: Inputs change at the falling edge.
// Notes: Core model result is channel and a bias byte.
`default_nettype none
module tb
	import asq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = '0, srst = '1, clkEn = '1, swStartA = '0, swStartB = '0, stopReq = '0;
	logic intRefEn = '0, averageEnable = '0, doubleTrigEnable = '0, doubleTrigExtEn = '0;
	logic groupAPriorityEn = '0, groupBRestartEn = '0, groupBRepeatScan = '0, autoClearEn = '0;
	logic extAsyncTriggerPinN = '1, transferEnMain = '1, transferEnB = '1, rdEn = '0;
	logic [1:0]          scanMode = '0;
	logic [NUM_CH-1:0]   chanSelA = '0, chanSelB = '0, addChanSel = '0;
	logic [ADDC_W-1:0]   addCount = '0;
	logic [TSEL_W-1:0]   groupATriggerSel = 6'h3f, groupBTriggerSel = 6'h3f;
	logic [TRIG_N-1:0]   timerTrig = '0;
	logic [DBL_W-1:0]    doubleTrigChannelSel = '0, disconnectAssistSel = 5'h15;
	logic [SAMP_W-1:0]   samplingStates = 8'h0c, shSamplingTime = 8'h21, convSampleStates;
	logic [7:0]          resBias = 8'h55, lat = 8'h04;
	logic [MEM_AW-1:0]   rdIdx = '0;
	logic convStart, convAbort, convIntRef, convDone, scanEndIrq, groupBEndIrq;
	logic transferReqMain, transferReqB, doublePending;
	logic [CH_W-1:0]     convChannel;
	logic [ASSIST_W-1:0] convAssist;
	logic [RES_W-1:0]    convResult;
	logic [DATA_W-1:0]   rdData;
	int                  error_cnt = 0, comparisons = 0, nA = 0, nB = 0, nAb = 0, nSt = 0;
	logic [CH_W-1:0]     chq [$];
	asq_scan_seq asq_scan_seq_i (.mclk, .srst, .clkEn, .scanMode, .swStartA, .swStartB, .stopReq,
		.chanSelA, .chanSelB, .intRefEn, .addChanSel, .addCount, .averageEnable, .groupATriggerSel,
		.groupBTriggerSel, .timerTrig, .extAsyncTriggerPinN, .doubleTrigEnable,
		.doubleTrigChannelSel, .doubleTrigExtEn, .groupAPriorityEn, .groupBRestartEn,
		.groupBRepeatScan, .samplingStates, .shSamplingTime, .disconnectAssistSel, .autoClearEn,
		.transferEnMain, .transferEnB, .convStart, .convAbort, .convChannel, .convIntRef,
		.convSampleStates, .convAssist, .convDone, .convResult, .rdEn, .rdIdx, .rdData,
		.scanEndIrq, .groupBEndIrq, .transferReqMain, .transferReqB, .doublePending);
	asq_core_model asq_core_model_i (.mclk, .convStart, .convAbort, .convChannel, .resBias, .lat,
		.convDone, .convResult);
	initial forever #50 mclk = ~mclk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		if (scanEndIrq === 1'h1) nA <= nA + 1;
		if (groupBEndIrq === 1'h1) nB <= nB + 1;
		if (convAbort === 1'h1) nAb <= nAb + 1;
		if (scanEndIrq === 1'h1) check(transferReqMain, 1'h1);
		if (groupBEndIrq === 1'h1) check(transferReqB, 1'h1);
		if (convStart === 1'h1)
		begin
			nSt <= nSt + 1;
			chq.push_back(convChannel);
			check(convSampleStates, convChannel < 3 ? shSamplingTime : samplingStates);
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic pulse(ref logic s);
		s = '1;
		cyc(1);
		s = '0;
	endtask
	task automatic waitfor(ref int c, input int tgt);
		for (int k = 0; k < 400 && c < tgt; k++) cyc(1);
		if (c < tgt)
		begin
			error_cnt++;
			$display("ERROR %0t wait timed out", $time);
		end
	endtask
	task automatic clr;
		nA = 0;
		nB = 0;
		nAb = 0;
		nSt = 0;
		chq.delete();
	endtask
	task automatic rdchk(input logic [3:0] i, input logic [15:0] e);
		rdIdx = i;
		rdEn = '1;
		cyc(1);
		check(rdData, e);
		rdEn = '0;
		cyc(1);
	endtask
	task automatic t_single;
		clr();
		chanSelA = 10'h205;
		intRefEn = '1;
		pulse(swStartA);
		waitfor(nA, 1);
		cyc(20);
		check(nA, 1);
		check({chq[0], chq[1], chq[2], chq[3]}, 16'h029a);
		check(nSt, 4);
		rdchk(4'h9, 16'h0955);
		rdchk(IDX_INTREF, 16'h0a55);
		intRefEn = '0;
	endtask
	task automatic t_cont;
		int k;
		clr();
		scanMode = 2'h1;
		chanSelA = 10'h003;
		pulse(swStartA);
		waitfor(nSt, 6);
		pulse(stopReq);
		cyc(2);
		k = nSt;
		cyc(30);
		check(nSt, k);
		check({chq[4], chq[5]}, 8'h01);
		scanMode = 2'h0;
	endtask
	task automatic t_group;
		clr();
		scanMode = 2'h2;
		chanSelA = 10'h002;
		chanSelB = 10'h030;
		groupBTriggerSel = 6'h03;
		groupATriggerSel = TSEL_EXT;
		timerTrig = 32'h20;
		cyc(10);
		check(nSt, 0);
		timerTrig = 32'h08;
		cyc(1);
		timerTrig = '0;
		waitfor(nB, 1);
		check({nA[3:0], chq[0], chq[1]}, 12'h045);
		extAsyncTriggerPinN = '0;
		cyc(8);
		extAsyncTriggerPinN = '1;
		waitfor(nA, 1);
		check({nA[3:0], nB[3:0], chq[2]}, 12'h111);
	endtask
	task automatic t_preempt;
		clr();
		groupAPriorityEn = '1;
		groupBRestartEn = '1;
		lat = 8'h14;
		chanSelB = 10'h1f0;
		pulse(swStartB);
		waitfor(nSt, 1);
		cyc(5);
		pulse(swStartA);
		waitfor(nB, 1);
		check({nAb[3:0], nA[3:0], chq[1]}, 12'h111);
		check({chq[2], chq[6]}, 8'h48);
		check(nSt, 7);
		lat = 8'h04;
		groupAPriorityEn = '0;
		groupBRestartEn = '0;
		scanMode = 2'h0;
	endtask
	task automatic t_repeat;
		clr();
		scanMode = 2'h2;
		chanSelB = 10'h001;
		groupBRepeatScan = '1;
		pulse(swStartB);
		waitfor(nB, 3);
		pulse(stopReq);
		cyc(30);
		check(nB, 3);
		check(nA, 0);
		groupBRepeatScan = '0;
		scanMode = 2'h0;
	endtask
	task automatic t_extdbl;
		clr();
		groupATriggerSel = 6'h02;
		doubleTrigChannelSel = 5'h05;
		doubleTrigEnable = '1;
		doubleTrigExtEn = '1;
		resBias = 8'h31;
		repeat (2)
		begin
			timerTrig = 32'h04;
			cyc(1);
			timerTrig = '0;
			cyc(20);
			resBias = 8'h32;
		end
		check(nA, 1);
		rdchk(4'h5, 16'h0531);
		rdchk(IDX_DUPA, 16'h0532);
		rdchk(IDX_DUP, 16'h0322);
		doubleTrigEnable = '0;
		doubleTrigExtEn = '0;
		resBias = 8'h55;
	endtask
	task automatic t_double;
		clr();
		chanSelA = 10'h008;
		doubleTrigChannelSel = 5'h03;
		doubleTrigEnable = '1;
		resBias = 8'h11;
		pulse(swStartA);
		cyc(20);
		check({doublePending, nA[3:0]}, 5'h10);
		resBias = 8'h22;
		pulse(swStartA);
		waitfor(nA, 1);
		check(nA, 1);
		rdchk(4'h3, 16'h0311);
		rdchk(IDX_DUP, 16'h0322);
		doubleTrigEnable = '0;
		resBias = 8'h55;
	endtask
	task automatic t_add;
		clr();
		chanSelA = 10'h040;
		addChanSel = 10'h040;
		addCount = 3'h3;
		pulse(swStartA);
		waitfor(nA, 1);
		check(nSt, 4);
		rdchk(4'h6, 16'h1954);
		averageEnable = '1;
		pulse(swStartA);
		waitfor(nA, 2);
		autoClearEn = '1;
		rdchk(4'h6, 16'h0655);
		rdchk(4'h6, 16'h0000);
	endtask
	initial
	begin
		cyc(6);
		srst = '0;
		cyc(1);
		t_single();
		t_cont();
		t_group();
		t_preempt();
		t_repeat();
		t_double();
		t_extdbl();
		t_add();
		end_sim();
	end
	initial
	begin
		#1000000;
		error_cnt++;
		end_sim();
	end
endmodule // tb
`default_nettype wire
